// ==== pkg/rtcs_pkg.sv ====
// Purpose: shared constants, state layout and helpers for the clock status logic
// Assumes: registers appear in their printed bit order at the access port
// Notes: time counters are held as natural BCD inside the block
package rtcs_pkg;
  // time base, counted in oscillator periods
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = 15;
  localparam int LSD_WINDOW_US = 15600;
  localparam int LSD_WINDOW_TICKS = (LSD_WINDOW_US * OSC_HZ + 999999) / 1000000;
  localparam int PULSE2_US = 7810;
  localparam int PULSE2_TICKS = (PULSE2_US * OSC_HZ + 999999) / 1000000;
  localparam logic [DIV_W-1:0] LSD_LAST = DIV_W'(LSD_WINDOW_TICKS - 1);
  localparam logic [DIV_W-1:0] PULSE2_END = DIV_W'(PULSE2_TICKS);

  // register indices at the access port
  localparam logic [4:0] REG_ST1 = 5'h00;
  localparam logic [4:0] REG_ST2 = 5'h01;
  localparam logic [4:0] REG_YEAR = 5'h02;
  localparam logic [4:0] REG_MONTH = 5'h03;
  localparam logic [4:0] REG_DAY = 5'h04;
  localparam logic [4:0] REG_WDAY = 5'h05;
  localparam logic [4:0] REG_HOUR = 5'h06;
  localparam logic [4:0] REG_MIN = 5'h07;
  localparam logic [4:0] REG_SEC = 5'h08;
  localparam logic [4:0] REG_FIRST_FREQ_SELECT = 5'h09;
  localparam logic [4:0] REG_SECOND_FREQ_SELECT = 5'h0C;
  localparam logic [4:0] REG_CORR = 5'h0F;
  localparam logic [4:0] REG_FREE = 5'h10;

  // status one bits
  localparam int ST1_RESET = 7;
  localparam int ST1_MODE24 = 6;
  localparam int ST1_SC0 = 5;
  localparam int ST1_SC1 = 4;
  localparam int ST1_INT1F = 3;
  localparam int ST1_INT2F = 2;
  localparam int ST1_BLD = 1;
  localparam int ST1_POC = 0;
  // status two bits, then the frequency select low bit and the alarm byte enable bit
  localparam int ST2_INT1FE = 7;
  localparam int ST2_INT1ME = 6;
  localparam int ST2_FIRST_ALARM_ENABLE = 5;
  localparam int ST2_EXT32 = 4;
  localparam int ST2_INT2FE = 3;
  localparam int ST2_INT2ME = 2;
  localparam int ST2_SECOND_ALARM_ENABLE = 1;
  localparam int FREQ_LO = 3;
  localparam int ALM_EN = 7;

  // power-on values
  localparam logic [7:0] ST1_POR = 8'h01;
  localparam logic [7:0] ST2_POR = 8'h80;
  localparam logic [7:0] FIRST_FREQ_SELECT_POR = 8'h80;
  localparam logic [7:0] BYTE_CLR = 8'h00;
  localparam logic [4:0] MONTH_POR = 5'h01;
  localparam logic [5:0] DAY_POR = 6'h01;

  // calendar limits in BCD
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_DAY = 8'h31;
  localparam logic [7:0] MAX_H24 = 8'h23;
  localparam logic [7:0] MAX_H12 = 8'h11;
  localparam logic [7:0] MAX_MS = 8'h59;
  localparam logic [7:0] NOON = 8'h12;
  localparam logic [7:0] HALF_MIN = 8'h30;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [2:0] WDAY_BAD = 3'h7;

  typedef struct packed {
    logic powerup_flag;
    logic low_supply_flag;
    logic a1f;
    logic a2f;
    logic sc0;
    logic sc1;
    logic mode24;
    logic [7:0] st2;
    logic [2:0][7:0] first_freq_select;
    logic [2:0][7:0] second_freq_select;
    logic [7:0] corr;
    logic [7:0] free;
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic pm;
    logic [6:0] minute;
    logic [6:0] second;
    logic [DIV_W-1:0] div;
    logic osc_d;
    logic lsd_run;
    logic lsd_seen;
    logic carry_sec;
    logic min_tick;
    logic min_upd;
    logic [7:0] rdata;
  } rtcs_state_t;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : rev8
endpackage : rtcs_pkg

// ==== design/rtcs_alarm_unit.sv ====
// Purpose: alarm compare and latched pin request for one interrupt pin
// Assumes: eval_in pulses the cycle after the minute counter changed
// Notes: a re-enable inside a match period waits for the next evaluation
`timescale 1ns/1ps
`default_nettype none
module rtcs_alarm_unit (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic alarm_on_in,
  input wire logic eval_in,
  // alarm fields, natural order
  input wire logic wday_en_in,
  input wire logic [2:0] wday_in,
  input wire logic hour_en_in,
  input wire logic [6:0] hour_in,
  input wire logic min_en_in,
  input wire logic [6:0] min_in,
  // current time, hour carries the am/pm bit on top
  input wire logic [2:0] now_wday_in,
  input wire logic [6:0] now_hour_in,
  input wire logic [6:0] now_min_in,
  // results
  output logic pin_low_out,
  output logic flag_set_out
);
  typedef struct packed {
    logic pin_low;
    logic flag_set;
  } rtcs_alm_t;

  rtcs_alm_t s;
  rtcs_alm_t next_s;
  logic match;
  logic fire;

  always_comb begin
    match = (wday_en_in | hour_en_in | min_en_in)
      & (!wday_en_in | (wday_in == now_wday_in))
      & (!hour_en_in | (hour_in == now_hour_in))
      & (!min_en_in | (min_in == now_min_in));
    // fires only on a fresh evaluation, not on re-enable itself
    fire = eval_in & alarm_on_in & match & !s.pin_low;
    next_s.pin_low = alarm_on_in & (s.pin_low | fire);
    next_s.flag_set = fire;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_low_out = s.pin_low;
  assign flag_set_out = s.flag_set;
endmodule : rtcs_alarm_unit
`default_nettype wire

// ==== design/rtcs_pin_mux.sv ====
// Purpose: output mode selection for one interrupt pin
// Assumes: mode bits come straight from status two
// Notes: EXTRA enables the modes only the first pin offers
`timescale 1ns/1ps
`default_nettype none
module rtcs_pin_mux #(
  parameter bit EXTRA = 1'b1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // mode bits
  input wire logic ext_in,
  input wire logic ae_in,
  input wire logic me_in,
  input wire logic fe_in,
  // frequency select and square waves, 1 Hz in the top bit
  input wire logic [4:0] sel_in,
  input wire logic [4:0] phase_in,
  // timing
  input wire logic osc_level_in,
  input wire logic min_tick_in,
  input wire logic sec_lt30_in,
  input wire logic win2_in,
  input wire logic alarm_low_in,
  // pin
  output logic drive_low_out
);
  typedef struct packed {
    logic armed;
    logic drive_low;
  } rtcs_pin_t;

  rtcs_pin_t s;
  rtcs_pin_t next_s;

  always_comb begin
    next_s = s;
    // minute modes start at the first carry after selection
    if (!me_in) begin
      next_s.armed = 1'b0;
    end else if (min_tick_in) begin
      next_s.armed = 1'b1;
    end
    if (EXTRA && ext_in) begin
      next_s.drive_low = !osc_level_in;
    end else if (!me_in && fe_in) begin
      // and of selected waves; nothing selected leaves the pin released
      next_s.drive_low = (|sel_in) & !(&(phase_in | ~sel_in));
    end else if (me_in && !fe_in) begin
      next_s.drive_low = next_s.armed;
    end else if (me_in && fe_in && ae_in && EXTRA) begin
      next_s.drive_low = s.armed & win2_in;
    end else if (me_in && fe_in) begin
      next_s.drive_low = s.armed & sec_lt30_in;
    end else if (ae_in) begin
      next_s.drive_low = alarm_low_in;
    end else begin
      next_s.drive_low = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign drive_low_out = s.drive_low;
endmodule : rtcs_pin_mux
`default_nettype wire

// ==== design/rtcs_status_core.sv ====
// Purpose: status, calendar, alarm and supply-flag logic of the clock
// Assumes: accesses arrive already decoded from the serial interface
// Notes: asynchronous reset stands for power-on detection
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - frequency bits B7..B3 pick 1..16 Hz, ANDed onto the pin
// - low three bits of each frequency register are plain storage, but B0 also enables the weekday alarm
// - one free byte of read/write storage with no effect
// - power-on loads documented time and register defaults
// - power-on sets power-up flag and 1 Hz output on first pin
// - software init clears power-up flag and ends that output
// - software init resets time, loads status one B6..B4 from the written byte, clears rest
// - supply sampled once per second for a 15.6 ms window
// - low sample sets flag, stops sampling, flag holds after recovery
// - reading the flag restarts sampling; good sample then clears it
// - invalid written date values replaced by 00, 01 or 0
// - invalid written hour and minute values replaced by 00
// - invalid seconds fixed at next carry, which bumps minutes
// - nonexistent day moves to first of next month
// - both pins offer four modes; first adds periodic two and 32 kHz
// - alarm match drives pin low until alarm enable cleared
// - re-enable during the same match period does not refire
// - hour-only alarm re-enabled in its hour refires next minute
// - each alarm byte has its own enable in B0
// - alarm flags set on match, cleared once read
module rtcs_status_core
  import rtcs_pkg::*;
(
  // clock and power-on reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // oscillator and supply comparator
  input wire logic osc_level_in,
  input wire logic supply_low_in,
  // register access
  input wire logic [4:0] reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // interrupt pins, open drain
  output logic first_irq_pin_out,
  output logic first_irq_pin_oe_out,
  output logic second_irq_pin_out,
  output logic second_irq_pin_oe_out,
  // correction byte for the rate trimmer
  output logic [7:0] rate_correction_out
);
  rtcs_state_t s;
  rtcs_state_t n;
  logic osc_tick;
  logic sec_tick;
  logic [7:0] wnat;
  logic pm_read;
  logic [7:0] a1w, a1h, a1m, a2w, a2h, a2m;
  logic alm1_on, alm2_on;
  logic alm1_low, alm2_low, alm1_set, alm2_set;
  logic pin1_low, pin2_low;
  logic win2;

  function automatic logic bcd_ok(input logic [7:0] v);
    return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
  endfunction : bcd_ok

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] dim(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
      : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: dim = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  endfunction : dim

  assign osc_tick = osc_level_in & ~s.osc_d;
  assign sec_tick = osc_tick & (&s.div);
  assign wnat = rev8(reg_wdata_in);
  // in 24-hour mode the am/pm bit is derived, not stored
  assign pm_read = s.mode24 ? ({2'b00, s.hour} >= NOON) : s.pm;
  assign win2 = s.carry_sec & (s.div < PULSE2_END);
  assign a1w = rev8(s.first_freq_select[0]);
  assign a1h = rev8(s.first_freq_select[1]);
  assign a1m = rev8(s.first_freq_select[2]);
  assign a2w = rev8(s.second_freq_select[0]);
  assign a2h = rev8(s.second_freq_select[1]);
  assign a2m = rev8(s.second_freq_select[2]);
  assign alm1_on = !s.st2[ST2_EXT32] & s.st2[ST2_FIRST_ALARM_ENABLE]
    & !s.st2[ST2_INT1ME] & !s.st2[ST2_INT1FE];
  assign alm2_on = s.st2[ST2_SECOND_ALARM_ENABLE] & !s.st2[ST2_INT2ME]
    & !s.st2[ST2_INT2FE];

  always_comb begin
    logic mc, hc, dc, moc, yc, init;
    logic [7:0] v;
    mc = 1'b0;
    hc = 1'b0;
    dc = 1'b0;
    moc = 1'b0;
    yc = 1'b0;
    init = 1'b0;
    v = 8'h00;
    n = s;
    n.osc_d = osc_level_in;
    n.min_tick = 1'b0;
    n.min_upd = 1'b0;
    if (osc_tick) begin
      n.div = s.div + DIV_W'(1);
    end

    // supply sampling window at the start of each second
    if (osc_tick && s.lsd_run && s.div <= LSD_LAST && supply_low_in) begin
      n.lsd_seen = 1'b1;
    end
    if (osc_tick && s.div == LSD_LAST) begin
      if (s.lsd_run) begin
        if (s.lsd_seen || supply_low_in) begin
          n.low_supply_flag = 1'b1;
          n.lsd_run = 1'b0;
        end else begin
          n.low_supply_flag = 1'b0;
        end
      end
      n.lsd_seen = 1'b0;
    end

    // calendar advance
    if (sec_tick) begin
      if (bcd_ok({1'b0, s.second}) && {1'b0, s.second} < MAX_MS) begin
        n.second = 7'(bcd_inc({1'b0, s.second}));
      end else begin
        n.second = 7'h00;
        mc = 1'b1;
      end
      n.carry_sec = mc;
      n.min_tick = mc;
      n.min_upd = mc;
      if (mc) begin
        if ({1'b0, s.minute} == MAX_MS) begin
          n.minute = 7'h00;
          hc = 1'b1;
        end else begin
          n.minute = 7'(bcd_inc({1'b0, s.minute}));
        end
      end
      if (hc) begin
        if (s.mode24 && {2'b00, s.hour} == MAX_H24) begin
          n.hour = 6'h00;
          dc = 1'b1;
        end else if (!s.mode24 && {2'b00, s.hour} == MAX_H12) begin
          n.hour = 6'h00;
          n.pm = !s.pm;
          dc = s.pm;
        end else begin
          n.hour = 6'(bcd_inc({2'b00, s.hour}));
        end
      end
      if (dc) begin
        n.wday = (s.wday == WDAY_LAST) ? 3'h0 : s.wday + 3'h1;
        if ({2'b00, s.day} == dim(s.month, s.year)) begin
          n.day = DAY_POR;
          moc = 1'b1;
        end else begin
          n.day = 6'(bcd_inc({2'b00, s.day}));
        end
      end
    end

    // register writes, printed bit order converted for time data
    if (reg_wr_in) begin
      case (reg_sel_in)
        REG_ST1: begin
          n.mode24 = reg_wdata_in[ST1_MODE24];
          n.sc0 = reg_wdata_in[ST1_SC0];
          n.sc1 = reg_wdata_in[ST1_SC1];
          init = reg_wdata_in[ST1_RESET];
        end
        REG_ST2: n.st2 = reg_wdata_in;
        REG_YEAR: n.year = bcd_ok(wnat) ? wnat : 8'h00;
        REG_MONTH: begin
          v = {3'b000, wnat[4:0]};
          n.month = (bcd_ok(v) && v != 8'h00 && v <= MAX_MONTH)
            ? v[4:0] : MONTH_POR;
        end
        REG_DAY: begin
          v = {2'b00, wnat[5:0]};
          n.day = (bcd_ok(v) && v != 8'h00 && v <= MAX_DAY)
            ? v[5:0] : DAY_POR;
        end
        REG_WDAY: begin
          n.wday = (wnat[2:0] == WDAY_BAD) ? 3'h0 : wnat[2:0];
          n.min_upd = 1'b1;
        end
        REG_HOUR: begin
          v = {2'b00, wnat[5:0]};
          n.hour = (bcd_ok(v) && v <= (s.mode24 ? MAX_H24 : MAX_H12))
            ? v[5:0] : 6'h00;
          n.pm = s.mode24 ? 1'b0 : wnat[6];
          n.min_upd = 1'b1;
        end
        REG_MIN: begin
          v = {1'b0, wnat[6:0]};
          n.minute = (bcd_ok(v) && v <= MAX_MS) ? v[6:0] : 7'h00;
          n.min_upd = 1'b1;
        end
        // invalid seconds stay until the next carry repairs them
        REG_SEC: n.second = wnat[6:0];
        REG_FIRST_FREQ_SELECT: n.first_freq_select[0] = reg_wdata_in;
        REG_FIRST_FREQ_SELECT + 5'h01: n.first_freq_select[1] = reg_wdata_in;
        REG_FIRST_FREQ_SELECT + 5'h02: n.first_freq_select[2] = reg_wdata_in;
        REG_SECOND_FREQ_SELECT: n.second_freq_select[0] = reg_wdata_in;
        REG_SECOND_FREQ_SELECT + 5'h01: n.second_freq_select[1] = reg_wdata_in;
        REG_SECOND_FREQ_SELECT + 5'h02: n.second_freq_select[2] = reg_wdata_in;
        REG_CORR: n.corr = reg_wdata_in;
        REG_FREE: n.free = reg_wdata_in;
        default: n.st2 = n.st2;
      endcase
    end

    // nonexistent day rolls to the first of the next month
    if ({2'b00, n.day} > dim(n.month, n.year)) begin
      n.day = DAY_POR;
      moc = 1'b1;
    end
    if (moc) begin
      if ({3'b000, n.month} == MAX_MONTH) begin
        n.month = MONTH_POR;
        yc = 1'b1;
      end else begin
        n.month = 5'(bcd_inc({3'b000, n.month}));
      end
    end
    if (yc) begin
      n.year = (n.year == 8'h99) ? 8'h00 : bcd_inc(n.year);
    end

    // register reads; read side effects land the same cycle
    if (reg_rd_in) begin
      case (reg_sel_in)
        REG_ST1: begin
          n.rdata = {1'b0, s.mode24, s.sc0, s.sc1, s.a1f, s.a2f, s.low_supply_flag, s.powerup_flag};
          n.powerup_flag = 1'b0;
          n.a1f = 1'b0;
          n.a2f = 1'b0;
          n.lsd_run = 1'b1;
        end
        REG_ST2: n.rdata = s.st2;
        REG_YEAR: n.rdata = rev8(s.year);
        REG_MONTH: n.rdata = rev8({3'b000, s.month});
        REG_DAY: n.rdata = rev8({2'b00, s.day});
        REG_WDAY: n.rdata = rev8({5'b00000, s.wday});
        REG_HOUR: n.rdata = rev8({1'b0, pm_read, s.hour});
        REG_MIN: n.rdata = rev8({1'b0, s.minute});
        REG_SEC: n.rdata = rev8({1'b0, s.second});
        REG_FIRST_FREQ_SELECT: n.rdata = s.first_freq_select[0];
        REG_FIRST_FREQ_SELECT + 5'h01: n.rdata = s.first_freq_select[1];
        REG_FIRST_FREQ_SELECT + 5'h02: n.rdata = s.first_freq_select[2];
        REG_SECOND_FREQ_SELECT: n.rdata = s.second_freq_select[0];
        REG_SECOND_FREQ_SELECT + 5'h01: n.rdata = s.second_freq_select[1];
        REG_SECOND_FREQ_SELECT + 5'h02: n.rdata = s.second_freq_select[2];
        REG_CORR: n.rdata = s.corr;
        REG_FREE: n.rdata = s.free;
        default: n.rdata = 8'h00;
      endcase
    end

    // a match in the same cycle as the read clear is kept
    if (alm1_set) begin
      n.a1f = 1'b1;
    end
    if (alm2_set) begin
      n.a2f = 1'b1;
    end

    // software initialization overrides everything above
    if (init) begin
      n.powerup_flag = 1'b0;
      n.low_supply_flag = 1'b0;
      n.a1f = 1'b0;
      n.a2f = 1'b0;
      n.st2 = BYTE_CLR;
      n.first_freq_select = '0;
      n.second_freq_select = '0;
      n.corr = BYTE_CLR;
      n.free = BYTE_CLR;
      n.year = 8'h00;
      n.month = MONTH_POR;
      n.day = DAY_POR;
      n.wday = 3'h0;
      n.hour = 6'h00;
      n.pm = 1'b0;
      n.minute = 7'h00;
      n.second = 7'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
      s.powerup_flag <= ST1_POR[ST1_POC];
      s.st2 <= ST2_POR;
      s.first_freq_select[0] <= FIRST_FREQ_SELECT_POR;
      s.month <= MONTH_POR;
      s.day <= DAY_POR;
      s.lsd_run <= 1'b1;
    end else begin
      s <= n;
    end
  end

  rtcs_alarm_unit u_alarm1 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .alarm_on_in(alm1_on),
    .eval_in(s.min_upd),
    .wday_en_in(a1w[ALM_EN]),
    .wday_in(a1w[2:0]),
    .hour_en_in(a1h[ALM_EN]),
    .hour_in(a1h[6:0]),
    .min_en_in(a1m[ALM_EN]),
    .min_in(a1m[6:0]),
    .now_wday_in(s.wday),
    .now_hour_in({pm_read, s.hour}),
    .now_min_in(s.minute),
    .pin_low_out(alm1_low),
    .flag_set_out(alm1_set)
  );

  rtcs_alarm_unit u_alarm2 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .alarm_on_in(alm2_on),
    .eval_in(s.min_upd),
    .wday_en_in(a2w[ALM_EN]),
    .wday_in(a2w[2:0]),
    .hour_en_in(a2h[ALM_EN]),
    .hour_in(a2h[6:0]),
    .min_en_in(a2m[ALM_EN]),
    .min_in(a2m[6:0]),
    .now_wday_in(s.wday),
    .now_hour_in({pm_read, s.hour}),
    .now_min_in(s.minute),
    .pin_low_out(alm2_low),
    .flag_set_out(alm2_set)
  );

  rtcs_pin_mux #(.EXTRA(1'b1)) u_pin1 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .ext_in(s.st2[ST2_EXT32]),
    .ae_in(s.st2[ST2_FIRST_ALARM_ENABLE]),
    .me_in(s.st2[ST2_INT1ME]),
    .fe_in(s.st2[ST2_INT1FE]),
    .sel_in(s.first_freq_select[0][7:FREQ_LO]),
    .phase_in(s.div[DIV_W-1:DIV_W-5]),
    .osc_level_in(osc_level_in),
    .min_tick_in(s.min_tick),
    .sec_lt30_in({1'b0, s.second} < HALF_MIN),
    .win2_in(win2),
    .alarm_low_in(alm1_low),
    .drive_low_out(pin1_low)
  );

  // second pin lacks the 32 kHz and periodic-two modes
  rtcs_pin_mux #(.EXTRA(1'b0)) u_pin2 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .ext_in(1'b0),
    .ae_in(s.st2[ST2_SECOND_ALARM_ENABLE]),
    .me_in(s.st2[ST2_INT2ME]),
    .fe_in(s.st2[ST2_INT2FE]),
    .sel_in(s.second_freq_select[0][7:FREQ_LO]),
    .phase_in(s.div[DIV_W-1:DIV_W-5]),
    .osc_level_in(osc_level_in),
    .min_tick_in(s.min_tick),
    .sec_lt30_in({1'b0, s.second} < HALF_MIN),
    .win2_in(win2),
    .alarm_low_in(alm2_low),
    .drive_low_out(pin2_low)
  );

  assign reg_rdata_out = s.rdata;
  assign first_irq_pin_out = 1'b0;
  assign first_irq_pin_oe_out = pin1_low;
  assign second_irq_pin_out = 1'b0;
  assign second_irq_pin_oe_out = pin2_low;
  assign rate_correction_out = s.corr;
endmodule : rtcs_status_core
`default_nettype wire

// ==== test/rtcs_status_core_monitor.sv ====
// Purpose: port-level checks of the clock status core
// Assumes: register port and pin timing as handed over
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rtcs_status_core_monitor
  import rtcs_pkg::*;
(
  // clock, reset and register port
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [4:0] reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // pins and correction byte
  input wire logic first_irq_pin_out,
  input wire logic first_irq_pin_oe_out,
  input wire logic second_irq_pin_out,
  input wire logic [7:0] rate_correction_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_wr_free;
    reg_wr_in && reg_sel_in == REG_FREE;
  endsequence
  sequence s_rd_free;
    reg_rd_in && !reg_wr_in && reg_sel_in == REG_FREE;
  endsequence
  sequence s_modes_off;
    reg_wr_in && reg_sel_in == REG_ST2 && reg_wdata_in[7:4] == 4'h0;
  endsequence
  open_drain_a: assert property (!first_irq_pin_out && !second_irq_pin_out)
    else $error("pin value not low");
  unmapped_read_a: assert property (reg_rd_in && reg_sel_in > REG_FREE
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  corr_write_a: assert property (reg_wr_in && reg_sel_in == REG_CORR
    |=> rate_correction_out == $past(reg_wdata_in))
    else $error("correction byte not stored");
  scratch_free_a: assert property (s_wr_free ##1 !reg_wr_in ##1 s_rd_free
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("free byte lost");
  por_pulse_a: assert property ($rose(reset_n_in)
    |-> ##[1:3] first_irq_pin_oe_out) else $error("no pulse after power-on");
  init_quiet_a: assert property (reg_wr_in && reg_sel_in == REG_ST1
    && reg_wdata_in[ST1_RESET] |-> ##[1:3] !first_irq_pin_oe_out)
    else $error("pin still driven after init");
  modes_off_a: assert property (s_modes_off ##1 !reg_wr_in
    |-> ##1 !first_irq_pin_oe_out) else $error("pin driven with modes off");
  st1_top_a: assert property (reg_rd_in && reg_sel_in == REG_ST1
    |=> !reg_rdata_out[ST1_RESET]) else $error("init bit reads one");
  reset_quiet_a: assert property (disable iff (1'b0) !reset_n_in
    |-> reg_rdata_out == 8'h00 && !first_irq_pin_oe_out
    && rate_correction_out == 8'h00) else $error("outputs busy in reset");
endmodule : rtcs_status_core_monitor
bind rtcs_status_core rtcs_status_core_monitor mon (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .first_irq_pin_out(first_irq_pin_out),
  .first_irq_pin_oe_out(first_irq_pin_oe_out),
  .second_irq_pin_out(second_irq_pin_out),
  .rate_correction_out(rate_correction_out));
`default_nettype wire

// ==== test/rtcs_osc_model.sv ====
// Purpose: oscillator standing in for the crystal side
// Assumes: core clock period of 100 ns
// Notes: a tick every four core cycles; the true rate is far too slow
`timescale 1ns/1ps
`default_nettype none
module rtcs_osc_model (
  // oscillator square wave
  output var logic osc_level_out
);
  initial osc_level_out = 1'b0;
  always #200 osc_level_out = ~osc_level_out;
endmodule : rtcs_osc_model
`default_nettype wire

// ==== test/rtcs_status_core_tb_top.sv ====
// Purpose: self-checking bench of the clock status core
// Assumes: one oscillator tick per four core cycles
// Notes: no seconds carry happens within the run
`timescale 1ns/1ps
`default_nettype none
module rtcs_status_core_tb_top
  import rtcs_pkg::*;
;
  typedef struct packed {
    logic [4:0] s;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } rtcs_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic low = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc, o1, e1, o2, e2;
  logic [4:0] sel = 5'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat, corr;
  int failures = 0;
  int n_tests = 0;
  rtcs_row_t rows[$] = '{
    '{REG_ST2, 1'b0, 8'h00, 8'h80}, '{REG_FIRST_FREQ_SELECT, 1'b0, 8'h00, 8'h80},
    '{REG_MONTH, 1'b0, 8'h00, 8'h80}, '{REG_DAY, 1'b0, 8'h00, 8'h80},
    '{REG_CORR, 1'b0, 8'h00, 8'h00}, '{REG_ST1, 1'b0, 8'h00, 8'h01},
    '{REG_FREE, 1'b1, 8'h5A, 8'h5A}, '{REG_CORR, 1'b1, 8'hA5, 8'hA5},
    '{REG_SECOND_FREQ_SELECT, 1'b1, 8'h07, 8'h07}, '{5'h1F, 1'b1, 8'hFF, 8'h00},
    '{REG_MONTH, 1'b1, 8'hC8, 8'h80}, '{REG_DAY, 1'b1, 8'hAC, 8'h80},
    '{REG_WDAY, 1'b1, 8'hE0, 8'h00}, '{REG_YEAR, 1'b1, 8'h5C, 8'h00},
    '{REG_HOUR, 1'b1, 8'hA8, 8'h00}, '{REG_MIN, 1'b1, 8'hA6, 8'h00},
    '{REG_MONTH, 1'b1, 8'h20, 8'h20}, '{REG_DAY, 1'b1, 8'h8C, 8'h80},
    '{REG_MONTH, 1'b0, 8'h00, 8'hA0}};
  always #50 clk = ~clk;
  rtcs_osc_model osc_m (.osc_level_out(osc));
  rtcs_status_core dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .osc_level_in(osc), .supply_low_in(low), .reg_sel_in(sel),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .first_irq_pin_out(o1),
    .first_irq_pin_oe_out(e1), .second_irq_pin_out(o2),
    .second_irq_pin_oe_out(e2), .rate_correction_out(corr));
  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check8
  task automatic wreg(logic [4:0] s, logic [7:0] d);
    @(negedge clk);
    sel = s;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(logic [4:0] s, logic [7:0] exp);
    @(negedge clk);
    sel = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check8("rdata", exp, rdat);
  endtask : rreg
  task automatic pin(int n, logic exp);
    repeat (n) @(negedge clk);
    check8("pin", {7'h00, exp}, {7'h00, e1});
  endtask : pin
  // one 8 Hz period, so the count does not depend on phase
  task automatic duty(logic [7:0] exp);
    int cnt;
    cnt = 0;
    repeat (16384) begin
      @(negedge clk);
      cnt += int'(e1);
    end
    check8("duty", exp, 8'((cnt + 64) / 128));
  endtask : duty
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    #5_000_000;
    failures++;
    conclude();
  end
  initial begin
    // a real falling edge, so the reset acts before the first clock
    #1 rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    pin(2, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wreg(rows[i].s, rows[i].d);
      end
      rreg(rows[i].s, rows[i].e);
    end
    check8("corr", 8'hA5, corr);
    rst_n = 1'b0;
    low = 1'b1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2200) @(negedge clk);
    low = 1'b0;
    rreg(REG_ST1, 8'h03);
    rreg(REG_ST1, 8'h02);
    wreg(REG_FREE, 8'h5A);
    wreg(REG_ST1, 8'hB0);
    rreg(REG_ST1, 8'h30);
    rreg(REG_ST2, 8'h00);
    rreg(REG_FIRST_FREQ_SELECT, 8'h00);
    rreg(REG_FREE, 8'h00);
    pin(2, 1'b0);
    // second pin at 1 Hz, still in its first half-second
    wreg(REG_SECOND_FREQ_SELECT, 8'h80);
    wreg(REG_ST2, 8'h08);
    pin(2, 1'b0);
    check8("pin2", 8'h01, {7'h00, e2});
    wreg(REG_FIRST_FREQ_SELECT, 8'h08);
    wreg(REG_ST2, 8'h80);
    duty(8'h40);
    wreg(REG_FIRST_FREQ_SELECT, 8'h18);
    duty(8'h60);
    wreg(REG_ST2, 8'h00);
    wreg(REG_FIRST_FREQ_SELECT, 8'h00);
    wreg(REG_ST2, 8'h20);
    wreg(5'h0A, 8'h01);
    wreg(5'h0B, 8'h81);
    wreg(REG_MIN, 8'h80);
    pin(4, 1'b1);
    rreg(REG_ST1, 8'h38);
    rreg(REG_ST1, 8'h30);
    pin(1, 1'b1);
    wreg(REG_ST2, 8'h00);
    pin(3, 1'b0);
    wreg(REG_ST2, 8'h20);
    pin(5, 1'b0);
    conclude();
  end
endmodule : rtcs_status_core_tb_top
`default_nettype wire
